// ==== rtl/srcb_buffer.sv ====
// buffer-mode result ring: pointers, trigger interrupt, host read port
`timescale 1ns/100ps
`default_nettype none
module srcb_buffer #(
  parameter int DEPTH_P = srcb_pkg::DEPTH,
  parameter int IN_DEPTH_P = srcb_pkg::IN_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // converter side: inputs on the converter's own clock, ready from mclk flops
  input wire logic sar_clk_i,
  input wire logic sar_valid_i,
  input wire logic [srcb_pkg::SAR_W-1:0] sar_data_i,
  output logic sar_ready_o,
  // buffer configuration
  input wire logic buf_enable_i,
  input wire logic continuous_i,
  input wire logic self_ctrl_i,
  input wire logic [srcb_pkg::LVL_W-1:0] trigger_level_i,
  // register access from the serial front ends
  input wire logic reg_if_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // status toward the pin mux and the converter
  output logic data_avail_n_o,
  output logic conv_run_o,
  output logic [1:0] status_flags_o
);
  import srcb_pkg::*;

  localparam int PW = $clog2(DEPTH_P);
  localparam int CW = $clog2(DEPTH_P + 1);

  // =========================================================
  // state record
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic vld_s1;
    logic vld_s2;
    logic [SAR_W-1:0] dat_s1;
    logic [SAR_W-1:0] dat_s2;
    logic [DEPTH_P-1:0][WORD_W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW-1:0] trg;
    logic [CW-1:0] cnt;
    logic [7:0] ctl;
    logic [7:0] lsb_hold;
    logic mid;
    logic irq;
    srcb_state_t st;
    logic [7:0] rdata;
    logic rdy;
    logic [1:0] flags;
    logic run;
    logic avail_n;
  } srcb_st_t;

  srcb_st_t s_r, s_nxt;

  // =========================================================
  // decoded strobes
  logic sclk_rise;
  logic kind_ok;
  logic f_in_valid;
  logic f_in_ready;
  logic [WORD_W-1:0] f_out_data;
  logic f_out_valid;
  logic f_out_ready;
  logic buf_rd;
  logic upper_rd;
  logic lower_rd;
  logic ctl_rd;
  logic ctl_wr;
  logic pop_go;
  logic auto_hold;
  logic sw_hold;
  logic wr_go;
  logic [PW-1:0] lvl_step;
  logic [PW-1:0] lvl_loc;

  // edge found on the second and third stage only, never the first
  assign sclk_rise = s_r.sclk_s2 & ~s_r.sclk_d;

  // touch results need self control, the rest host control
  assign kind_ok = (s_r.dat_s2[TOUCH_POS] == self_ctrl_i);

  // a result is offered to the input fifo on a converter clock edge
  assign f_in_valid = sclk_rise & s_r.vld_s2 & kind_ok &
                      (s_r.st != ST_OFF);

  // register decode
  assign buf_rd = reg_rd_i & (reg_page_i == PAGE_BUF);
  assign upper_rd = buf_rd & (reg_addr_i == OFS_READ_UPPER);
  assign lower_rd = buf_rd & (reg_addr_i == OFS_READ_LOWER);
  assign ctl_rd = reg_rd_i & (reg_page_i == PAGE_CTL) &
                  (reg_addr_i == OFS_UPDATE_CTL);
  assign ctl_wr = reg_wr_i & (reg_page_i == PAGE_CTL) &
                  (reg_addr_i == OFS_UPDATE_CTL);

  // only the selected interface may take words out
  assign pop_go = upper_rd & (reg_if_i == s_r.ctl[IFSEL_POS]);

  // automatic halt: no ring write while a word is being read out
  assign auto_hold = ~s_r.ctl[HOLDMODE_POS] & (buf_rd | s_r.mid);
  // software halt only counts when hold mode selects it
  assign sw_hold = s_r.ctl[HOLDMODE_POS] & s_r.ctl[SWHOLD_POS];

  // a halted ring back-pressures the input fifo, not the results
  assign f_out_ready = (s_r.st != ST_OFF) & ~auto_hold & ~sw_hold;
  assign wr_go = f_out_valid & f_out_ready;

  // level counts single values; a level of 64 wraps to a zero step
  assign lvl_step = trigger_level_i[PW-1:0];
  assign lvl_loc = trigger_level_i[PW-1:0] - PW'(1);

  // =========================================================
  // input fifo between the converter and the ring
  srcb_fifo #(
    .W(WORD_W),
    .D(IN_DEPTH_P)
  ) u_in_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(s_r.dat_s2[WORD_W-1:0]),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );

  // =========================================================
  // next state
  always_comb begin
    logic [15:0] word;
    logic last;
    logic hit;
    word = '0;
    last = 1'b0;
    hit = 1'b0;
    s_nxt = s_r;

    // two-stage synchronisers for everything from the converter
    s_nxt.sclk_s1 = sar_clk_i;
    s_nxt.sclk_s2 = s_r.sclk_s1;
    s_nxt.sclk_d = s_r.sclk_s2;
    s_nxt.vld_s1 = sar_valid_i;
    s_nxt.vld_s2 = s_r.vld_s1;
    s_nxt.dat_s1 = sar_data_i;
    s_nxt.dat_s2 = s_r.dat_s1;

    // control register write, only the three defined bits stick
    if (ctl_wr) begin
      s_nxt.ctl = reg_wdata_i & CTL_MASK;
    end

    // ---- host reads ----
    if (upper_rd && pop_go) begin
      // flags travel with every word
      last = (s_r.cnt <= CW'(1));
      word[FULL_POS] = (s_r.cnt == CW'(DEPTH_P));
      word[EMPTY_POS] = last;
      // tag bit and result; bit 13 stays zero
      word[TAG_POS:0] = s_r.mem[s_r.rd];
      // upper byte to byte one, low byte kept for the next read
      s_nxt.rdata = word[15:8];
      s_nxt.lsb_hold = word[7:0];
      s_nxt.mid = 1'b1;
      if (s_r.cnt != '0) begin
        // read pointer names the next word to return
        s_nxt.rd = s_r.rd + PW'(1);
        s_nxt.cnt = s_r.cnt - CW'(1);
      end
      // an empty ring leaves the read pointer alone
    end else if (upper_rd) begin
      // unselected interface sees nothing and moves nothing
      s_nxt.rdata = '0;
    end else if (lower_rd) begin
      s_nxt.rdata = s_r.lsb_hold;
      s_nxt.mid = 1'b0;
    end else if (ctl_rd) begin
      s_nxt.rdata = s_r.ctl;
    end else if (reg_rd_i) begin
      s_nxt.rdata = '0;
    end

    // ---- interrupt release by reading ----
    if (pop_go) begin
      case (s_r.st)
        ST_WAIT: begin
          // first read of the finished set restarts conversion
          s_nxt.irq = 1'b0;
          s_nxt.st = ST_RUN;
          s_nxt.trg = s_r.trg + lvl_step;
        end
        ST_RUN: begin
          if (continuous_i) begin
            s_nxt.irq = 1'b0;
          end
        end
        default: begin
          s_nxt.irq = s_r.irq;
        end
      endcase
    end

    // ---- ring write, after the read so both may share a cycle ----
    if (wr_go) begin
      // result lands where the write pointer points
      s_nxt.mem[s_r.wr] = f_out_data;
      s_nxt.wr = s_r.wr + PW'(1);
      if (s_nxt.cnt == CW'(DEPTH_P)) begin
        // full: oldest word is lost, read pointer steps on
        s_nxt.rd = s_nxt.rd + PW'(1);
      end else begin
        s_nxt.cnt = s_nxt.cnt + CW'(1);
      end
      // written value count meets the trigger level
      hit = (s_r.wr == s_r.trg);
      if (continuous_i) begin
        // next write drops a pending interrupt
        s_nxt.irq = 1'b0;
      end
      if (hit && s_r.st == ST_RUN) begin
        // a new hit wins over the clear in the same cycle
        s_nxt.irq = 1'b1;
        if (continuous_i) begin
          s_nxt.trg = s_nxt.trg + lvl_step;
        end else begin
          s_nxt.st = ST_WAIT;
        end
      end
    end

    // ---- buffer mode off: hold state, pointers, count and interrupt at reset position ----
    if (!buf_enable_i) begin
      s_nxt.st = ST_OFF;
      s_nxt.wr = LOC_FIRST[PW-1:0];
      s_nxt.rd = LOC_FIRST[PW-1:0];
      s_nxt.trg = lvl_loc;
      s_nxt.cnt = '0;
      s_nxt.irq = 1'b0;
      s_nxt.mid = 1'b0;
    end else if (s_r.st == ST_OFF) begin
      s_nxt.st = ST_RUN;
    end

    // registered views of the ring state
    s_nxt.rdy = f_in_ready & (s_nxt.st != ST_OFF);
    s_nxt.flags[1] = (s_nxt.cnt == CW'(DEPTH_P));
    s_nxt.flags[0] = (s_nxt.cnt == '0);
    // pin views kept in flops so the outputs carry no decode glitches
    s_nxt.run = (s_nxt.st == ST_RUN);
    s_nxt.avail_n = ~s_nxt.irq;
  end

  // =========================================================
  // state register
  // the whole ring sits in flops; a memory macro would save area
  // but complicates the same-cycle read and overwrite
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.ctl <= CTL_RESET;
      s_r.st <= ST_OFF;
      s_r.flags <= 2'h1; // empty after reset
      s_r.avail_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =========================================================
  // outputs, all straight from flops
  assign reg_rdata_o = s_r.rdata;
  // pin is low while the trigger interrupt is pending
  assign data_avail_n_o = s_r.avail_n;
  assign conv_run_o = s_r.run;
  assign sar_ready_o = s_r.rdy;
  assign status_flags_o = s_r.flags;

endmodule
`default_nettype wire

// ==== rtl/srcb_fifo.sv ====
// small first-in first-out buffer for results on their way into the ring
`timescale 1ns/100ps
`default_nettype none
module srcb_fifo #(
  parameter int W = 13,
  parameter int D = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } srcb_fifo_st_t;
  srcb_fifo_st_t s_r, s_nxt;
  logic push, pop;

  // honest flags straight from the occupancy count
  assign in_ready_o = (s_r.cnt != CW'(D));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // =========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + AW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - CW'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/srcb_pkg.sv ====
// constants shared by the sar result circular buffer and its input fifo
`default_nettype none
package srcb_pkg;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int LVL_W = 7;
  localparam int IN_FIFO_DEPTH = 4;
  localparam int SAR_W = 14;  // kind bit, tag bit, 12-bit result
  localparam int WORD_W = 13; // tag bit and result
  localparam int TOUCH_POS = 13;
  localparam int RES_W = 12;
  // returned 16-bit word layout
  localparam int FULL_POS = 15;
  localparam int EMPTY_POS = 14;
  localparam int TAG_POS = 12;
  // register map
  localparam logic [7:0] PAGE_BUF = 8'hfc;
  localparam logic [7:0] PAGE_CTL = 8'h03;
  localparam logic [6:0] OFS_READ_UPPER = 7'h01;
  localparam logic [6:0] OFS_READ_LOWER = 7'h02;
  localparam logic [6:0] OFS_UPDATE_CTL = 7'h12;
  localparam int IFSEL_POS = 7;
  localparam int HOLDMODE_POS = 6;
  localparam int SWHOLD_POS = 5;
  localparam logic [7:0] CTL_MASK = 8'he0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [PTR_W-1:0] LOC_FIRST = 6'h00; // location 1
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_WAIT = 2'b11
  } srcb_state_t;
endpackage
`default_nettype wire

// ==== tb/srcb_buffer_asserts.sv ====
// checker for the buffer-mode ring ports, bound to srcb_buffer
`timescale 1ns/100ps
`default_nettype none
module srcb_buffer_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic buf_enable_i,
  input wire logic continuous_i,
  input wire logic reg_if_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic data_avail_n_o,
  input wire logic conv_run_o,
  input wire logic [1:0] status_flags_o
);
  import srcb_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // control bits as last written, so read-side properties know the mode
  logic [7:0] ctl_seen_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_seen_r <= CTL_RESET;
    end else if (reg_wr_i && reg_page_i == PAGE_CTL &&
                 reg_addr_i == OFS_UPDATE_CTL) begin
      ctl_seen_r <= reg_wdata_i & CTL_MASK;
    end
  end
  // ==========================================
  // buffer reset and status
  flags_reset_a: assert property (
    !buf_enable_i [*2] |=> status_flags_o == 2'b01)
    else $error("flags not cleared by buffer reset");
  irq_reset_a: assert property (
    !buf_enable_i [*2] |=> data_avail_n_o)
    else $error("interrupt active during buffer reset");
  flags_excl_a: assert property (status_flags_o != 2'b11)
    else $error("full and empty at once");
  // ==========================================
  // register port: readback masks the three control bits
  ctl_readback_a: assert property (
    reg_wr_i && reg_page_i == PAGE_CTL && reg_addr_i == OFS_UPDATE_CTL ##2
    reg_rd_i && reg_page_i == PAGE_CTL && reg_addr_i == OFS_UPDATE_CTL
    |=> reg_rdata_o == ($past(reg_wdata_i, 3) & CTL_MASK))
    else $error("control readback mismatch");
  rdata_hold_a: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  reserved_bit_a: assert property (
    reg_rd_i && reg_page_i == PAGE_BUF && reg_addr_i == OFS_READ_UPPER
    |=> !reg_rdata_o[5])
    else $error("reserved word bit set");
  // ==========================================
  // interrupt and conversion control
  cont_run_a: assert property (
    continuous_i && buf_enable_i [*3] |=> conv_run_o)
    else $error("continuous mode stopped converting");
  ss_hold_a: assert property (
    !data_avail_n_o && !continuous_i && buf_enable_i && !reg_rd_i
    |=> !data_avail_n_o)
    else $error("single-shot interrupt dropped without a read");
  // a selected-interface read under automatic hold is sure to clear,
  // since the hold then keeps a same-cycle trigger write out
  cont_clear_a: assert property (
    !data_avail_n_o && continuous_i && reg_rd_i &&
    reg_page_i == PAGE_BUF && reg_addr_i == OFS_READ_UPPER &&
    reg_if_i == ctl_seen_r[IFSEL_POS] && !ctl_seen_r[HOLDMODE_POS]
    |=> data_avail_n_o)
    else $error("continuous interrupt not cleared by read");
  irq_seen_c: cover property ($fell(data_avail_n_o));
  full_seen_c: cover property (status_flags_o == 2'b10);
  wait_seen_c: cover property (conv_run_o ##1 !conv_run_o);
endmodule
bind srcb_buffer srcb_buffer_asserts chk (.mclk_i, .rst_n_i, .buf_enable_i,
  .continuous_i, .reg_if_i, .reg_rd_i, .reg_wr_i, .reg_page_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .data_avail_n_o, .conv_run_o, .status_flags_o);
`default_nettype wire

// ==== tb/srcb_conv.sv ====
// converter model: one result per link clock frame of at least 167 ns
`timescale 1ns/100ps
`default_nettype none
module srcb_conv (
  input wire logic run_i,
  input wire logic ready_i,
  output logic sar_clk_o,
  output logic sar_valid_o,
  output logic [srcb_pkg::SAR_W-1:0] sar_data_o
);
  import srcb_pkg::*;
  // link clock stands low between frames
  initial begin
    sar_clk_o = 1'b0;
    sar_valid_o = 1'b0;
    sar_data_o = '0;
  end
  // converts once allowed or after 2000 waits of 20 ns; data inverted once released
  task automatic send(input logic [SAR_W-1:0] d);
    int n;
    n = 0;
    while (!(run_i && ready_i) && n < 2000) begin
      #20;
      n++;
    end
    #7;
    sar_data_o = d;
    sar_valid_o = 1'b1;
    #80 sar_clk_o = 1'b1;
    #80 sar_clk_o = 1'b0;
    sar_valid_o = 1'b0;
    sar_data_o = ~d;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the buffer-mode result ring
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; \
  if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  import srcb_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, buf_enable_i = 0, continuous_i = 1;
  logic self_ctrl_i = 1, reg_if_i = 1, reg_rd_i = 0, reg_wr_i = 0;
  logic [6:0] trigger_level_i = 7'h08, reg_addr_i = 0;
  logic [7:0] reg_page_i = 0, reg_wdata_i = 0, reg_rdata_o, b;
  wire logic sar_clk_i, sar_valid_i;
  wire logic [SAR_W-1:0] sar_data_i;
  logic sar_ready_o, data_avail_n_o, conv_run_o;
  logic [1:0] status_flags_o;
  logic [WORD_W-1:0] exp_q[$];
  logic [15:0] seed = 16'h91fb;
  int fails = 0, total_checks = 0, cyc = 0, lv;
  srcb_buffer uut (.mclk_i, .rst_n_i, .sar_clk_i, .sar_valid_i, .sar_data_i,
    .sar_ready_o, .buf_enable_i, .continuous_i, .self_ctrl_i,
    .trigger_level_i, .reg_if_i, .reg_page_i, .reg_addr_i, .reg_rd_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .data_avail_n_o, .conv_run_o,
    .status_flags_o);
  srcb_conv conv (.run_i(conv_run_o), .ready_i(sar_ready_o),
    .sar_clk_o(sar_clk_i), .sar_valid_o(sar_valid_i), .sar_data_o(sar_data_i));
  always #10 mclk_i = ~mclk_i;
  // ==========================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic settle();
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic acc(input logic w, input logic [7:0] p, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk_i);
    reg_page_i = p;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_rd_i = !w;
    reg_wr_i = w;
    @(negedge mclk_i);
    reg_rd_i = 0;
    reg_wr_i = 0;
    q = reg_rdata_o;
  endtask
  // expected word is built from the model queue, then popped
  task automatic get_word();
    logic [7:0] hi, lo;
    logic [15:0] e;
    e = {exp_q.size() == 64, exp_q.size() <= 1, 1'b0, exp_q[0]};
    acc(0, PAGE_BUF, OFS_READ_UPPER, 0, hi);
    acc(0, PAGE_BUF, OFS_READ_LOWER, 0, lo);
    `CHK("word", e, {hi, lo})
    void'(exp_q.pop_front());
  endtask
  // kind bit must match the control mode or the result is dropped
  task automatic send(input logic k, input logic t);
    seed = lfsr(seed);
    conv.send({k, t, seed[11:0]});
    if (k == self_ctrl_i) begin
      if (exp_q.size() == 64) void'(exp_q.pop_front());
      exp_q.push_back({t, seed[11:0]});
    end
  endtask
  task automatic restart(input logic c, input logic s, input int l);
    @(negedge mclk_i);
    buf_enable_i = 0;
    continuous_i = c;
    self_ctrl_i = s;
    trigger_level_i = l[6:0];
    repeat (3) @(negedge mclk_i);
    `CHK("reset flags", 2'b01, status_flags_o)
    buf_enable_i = 1;
    repeat (3) @(negedge mclk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1;
    `CHK("flags", 2'b01, status_flags_o)
    acc(0, PAGE_CTL, OFS_UPDATE_CTL, 0, b);
    `CHK("ctl", CTL_RESET, b)
    acc(1, PAGE_CTL, OFS_UPDATE_CTL, 8'hff, b);
    acc(0, PAGE_CTL, OFS_UPDATE_CTL, 0, b);
    `CHK("ctl", 8'he0, b)
    acc(1, PAGE_CTL, OFS_UPDATE_CTL, 8'h80, b);
    restart(1, 1, 8);
    reg_if_i = 0;
    acc(0, PAGE_BUF, OFS_READ_UPPER, 0, b);
    `CHK("other if", 8'h00, b)
    reg_if_i = 1;
    for (int i = 0; i < 8; i++) begin
      send(1, !i[0]);
      if (i == 5) send(0, 1);
      settle();
      if (i == 6) `CHK("no irq", 1'b1, data_avail_n_o)
    end
    `CHK("irq", 1'b0, data_avail_n_o)
    repeat (8) get_word();
    `CHK("irq clr", 1'b1, data_avail_n_o)
    acc(0, PAGE_BUF, OFS_READ_UPPER, 0, b);
    `CHK("empty word", 1'b1, b[6])
    // finish the byte pair, else the automatic hold keeps the ring shut
    acc(0, PAGE_BUF, OFS_READ_LOWER, 0, b);
    `CHK("empty", 2'b01, status_flags_o)
    send(1, 1);
    settle();
    get_word();
    // software hold parks a result in the input fifo until released
    acc(1, PAGE_CTL, OFS_UPDATE_CTL, 8'he0, b);
    send(1, 0);
    settle();
    `CHK("sw hold", 2'b01, status_flags_o)
    acc(1, PAGE_CTL, OFS_UPDATE_CTL, 8'hc0, b);
    settle();
    `CHK("sw run", 2'b00, status_flags_o)
    get_word();
    acc(1, PAGE_CTL, OFS_UPDATE_CTL, 8'h80, b);
    for (int i = 0; i < 66; i++) send(1, i[0]);
    settle();
    `CHK("full", 2'b10, status_flags_o)
    repeat (64) get_word();
    lv = seed % 8 + 1;
    restart(0, 0, lv);
    repeat (lv) send(0, 0);
    settle();
    `CHK("ss irq", 2'b00, {data_avail_n_o, conv_run_o})
    get_word();
    settle();
    `CHK("ss go", 2'b11, {data_avail_n_o, conv_run_o})
    repeat (lv) send(0, 1);
    settle();
    `CHK("ss irq2", 1'b0, data_avail_n_o)
    print_verdict();
  end
endmodule
`default_nettype wire
